// *** logic/i2c_regs_pkg.sv ***
package i2c_regs_pkg;

  // Register bus geometry.
  localparam int ADDR_WIDTH = 4;
  localparam int DATA_WIDTH = 16;

  // Register word offsets on the plain register port.
  localparam logic [ADDR_WIDTH-1:0] OFFSET_EXTENDED_MODE = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] OFFSET_INTERRUPT_ENABLE = 4'h1;
  localparam logic [ADDR_WIDTH-1:0] OFFSET_BUS_EVENT_STATUS = 4'h2;

  // Extended mode control field.
  localparam int BIT_COMPAT_TIMING = 0;
  localparam logic RESET_COMPAT_TIMING = 1'h1;

  // Interrupt enable and status low-half field positions.
  localparam int BIT_ARBITRATION_LOST = 0;
  localparam int BIT_NO_ACK = 1;
  localparam int BIT_ACCESS_READY = 2;
  localparam int BIT_RECEIVE_READY = 3;
  localparam int BIT_TRANSMIT_READY = 4;
  localparam int BIT_STOP_DETECTED = 5;
  localparam int BIT_ENABLE_ADDRESSED = 6;
  localparam int ENABLE_WIDTH = 7;
  localparam logic [ENABLE_WIDTH-1:0] RESET_ENABLE = 7'h00;

  // Status high-half field positions.
  localparam int BIT_GENERAL_CALL = 8;
  localparam int BIT_ADDRESSED_AS_SLAVE = 9;
  localparam int BIT_TRANSMITTER_EMPTY = 10;
  localparam int BIT_RECEIVE_SHIFT_FULL = 11;
  localparam int BIT_BUS_BUSY = 12;
  localparam int BIT_ACK_WITHHELD_SENT = 13;
  localparam int BIT_SLAVE_DIRECTION = 14;

  // Reset values of the read-only status levels.
  localparam logic RESET_TRANSMIT_READY = 1'h1;
  localparam logic RESET_TRANSMITTER_EMPTY = 1'h1;
  localparam logic RESET_OTHER_STATUS = 1'h0;

  // Write-one-to-clear flags, indexed 0 to W1C_COUNT-1.
  localparam int W1C_COUNT = 7;
  localparam int W1C_ARBITRATION_LOST = 0;
  localparam int W1C_NO_ACK = 1;
  localparam int W1C_ACCESS_READY = 2;
  localparam int W1C_RECEIVE_READY = 3;
  localparam int W1C_STOP_DETECTED = 4;
  localparam int W1C_ACK_WITHHELD_SENT = 5;
  localparam int W1C_SLAVE_DIRECTION = 6;

  // Maps a write-one-to-clear flag index to its status bit position.
  function automatic int w1c_position(input int index);
    int position;
    position = BIT_ARBITRATION_LOST;
    case (index)
      W1C_NO_ACK: position = BIT_NO_ACK;
      W1C_ACCESS_READY: position = BIT_ACCESS_READY;
      W1C_RECEIVE_READY: position = BIT_RECEIVE_READY;
      W1C_STOP_DETECTED: position = BIT_STOP_DETECTED;
      W1C_ACK_WITHHELD_SENT: position = BIT_ACK_WITHHELD_SENT;
      W1C_SLAVE_DIRECTION: position = BIT_SLAVE_DIRECTION;
      default: position = BIT_ARBITRATION_LOST;
    endcase
    return position;
  endfunction

endpackage

// *** logic/sticky_flag.sv ***
`timescale 1ns/1ps
`default_nettype none

// One hardware-set, software-cleared flag; a set in the clearing cycle wins.
module sticky_flag #(
  parameter logic RESET_VALUE = 1'h0
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rstn,
  // Set and clear requests.
  input wire logic i_set,
  input wire logic i_clear,
  // Flag state.
  output logic o_flag
);

  logic flag;
  logic next_flag;

  // Set has priority so an event in the clearing cycle is never lost.
  assign next_flag = i_set | (flag & ~i_clear);
  assign o_flag = flag;

  // State register.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      flag <= RESET_VALUE;
    end else begin
      flag <= next_flag;
    end
  end

endmodule // sticky_flag

`default_nettype wire

// *** logic/i2c_irq_enable_status_regs.sv ***
// What this block does
// - Compat timing bit zero, read/write, resets one.
// - Each interrupt source has own enable bit.
// - Enable bits at fixed positions, reset zero.
// - Enable bits fifteen to seven read zero.
// - Sixteen-bit status shows events and bus state.
// - Listed event status bits clear on one.
// - Listed status bits read-only, two reset one.
// - Slave direction cleared by loopback, start, stop.
// - Ack-withheld flag set on nack, reset clears.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module i2c_irq_enable_status_regs
  import i2c_regs_pkg::*;
#(
  parameter int ADDRESS_WIDTH = ADDR_WIDTH
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rstn,
  // Register port.
  input wire logic [ADDRESS_WIDTH-1:0] i_address,
  input wire logic [DATA_WIDTH-1:0] i_write_data,
  input wire logic i_write_strobe,
  input wire logic i_read_strobe,
  output logic [DATA_WIDTH-1:0] o_read_data,
  // Event pulses from the serial engine.
  input wire logic i_arbitration_lost_event,
  input wire logic i_no_ack_event,
  input wire logic i_access_ready_event,
  input wire logic i_receive_ready_event,
  input wire logic i_stop_detected_event,
  input wire logic i_ack_withheld_sent_event,
  input wire logic i_slave_transmit_addressed_event,
  input wire logic i_start_or_stop_seen,
  // Levels from the serial engine.
  input wire logic i_digital_loopback,
  input wire logic i_module_enable,
  input wire logic i_bus_busy,
  input wire logic i_receive_shift_full,
  input wire logic i_transmitter_empty,
  input wire logic i_addressed_as_slave,
  input wire logic i_general_call_address,
  input wire logic i_transmit_ready,
  // Control and interrupt outputs.
  output logic o_compat_timing_select,
  output logic [ENABLE_WIDTH-1:0] o_interrupt_enable,
  output logic o_interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // True when the address equals the given register offset; the strobe is applied by the caller.
  function automatic logic hit(input logic [ADDRESS_WIDTH-1:0] address,
                               input logic [ADDRESS_WIDTH-1:0] offset);
    return address == offset;
  endfunction

  wire logic write_extended_mode;
  wire logic write_interrupt_enable;
  wire logic write_bus_event_status;
  wire logic read_extended_mode;
  wire logic read_interrupt_enable;
  wire logic read_bus_event_status;

  // Each strobe qualified by its own register offset.
  assign write_extended_mode = i_write_strobe & hit(i_address, OFFSET_EXTENDED_MODE);
  assign write_interrupt_enable = i_write_strobe & hit(i_address, OFFSET_INTERRUPT_ENABLE);
  assign write_bus_event_status = i_write_strobe & hit(i_address, OFFSET_BUS_EVENT_STATUS);
  assign read_extended_mode = i_read_strobe & hit(i_address, OFFSET_EXTENDED_MODE);
  assign read_interrupt_enable = i_read_strobe & hit(i_address, OFFSET_INTERRUPT_ENABLE);
  assign read_bus_event_status = i_read_strobe & hit(i_address, OFFSET_BUS_EVENT_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Extended mode control.

  logic compat_timing_select;
  wire logic next_compat_timing_select;

  // Only the low bit is stored; upper write bits are dropped on the floor.
  assign next_compat_timing_select = write_extended_mode ?
                                     i_write_data[BIT_COMPAT_TIMING] :
                                     compat_timing_select;

  // Compat bit register, reset to one.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      compat_timing_select <= RESET_COMPAT_TIMING;
    end else begin
      compat_timing_select <= next_compat_timing_select;
    end
  end

  // The engine uses it to pick the transmit status flag timing.
  assign o_compat_timing_select = compat_timing_select;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable mask.

  logic [ENABLE_WIDTH-1:0] interrupt_enable_mask;
  wire logic [ENABLE_WIDTH-1:0] next_interrupt_enable_mask;

  // Bits fifteen to seven are not stored, so writes to them vanish.
  assign next_interrupt_enable_mask = write_interrupt_enable ?
                                      i_write_data[ENABLE_WIDTH-1:0] :
                                      interrupt_enable_mask;

  // Enable register, all sources off after reset.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      interrupt_enable_mask <= RESET_ENABLE;
    end else begin
      interrupt_enable_mask <= next_interrupt_enable_mask;
    end
  end

  assign o_interrupt_enable = interrupt_enable_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Write-one-to-clear event flags.

  wire logic [W1C_COUNT-1:0] w1c_set;
  wire logic [W1C_COUNT-1:0] w1c_extra_clear;
  wire logic [W1C_COUNT-1:0] w1c_flag;

  // Hardware set sources, one per flag.
  assign w1c_set[W1C_ARBITRATION_LOST] = i_arbitration_lost_event;
  assign w1c_set[W1C_NO_ACK] = i_no_ack_event;
  assign w1c_set[W1C_ACCESS_READY] = i_access_ready_event;
  assign w1c_set[W1C_RECEIVE_READY] = i_receive_ready_event;
  assign w1c_set[W1C_STOP_DETECTED] = i_stop_detected_event;
  assign w1c_set[W1C_ACK_WITHHELD_SENT] = i_ack_withheld_sent_event;
  assign w1c_set[W1C_SLAVE_DIRECTION] = i_slave_transmit_addressed_event;

  // Hardware clear sources besides the software write of one.
  assign w1c_extra_clear[W1C_ARBITRATION_LOST] = 1'h0;
  assign w1c_extra_clear[W1C_NO_ACK] = 1'h0;
  assign w1c_extra_clear[W1C_ACCESS_READY] = 1'h0;
  assign w1c_extra_clear[W1C_RECEIVE_READY] = 1'h0;
  assign w1c_extra_clear[W1C_STOP_DETECTED] = 1'h0;
  assign w1c_extra_clear[W1C_ACK_WITHHELD_SENT] = ~i_module_enable;
  assign w1c_extra_clear[W1C_SLAVE_DIRECTION] = i_digital_loopback |
                                                i_start_or_stop_seen;

  // One sticky cell per flag; a write of zero leaves the flag alone.
  genvar flag_index;
  generate
    for (flag_index = 0; flag_index < W1C_COUNT; flag_index++) begin : gen_w1c
      wire logic software_clear;
      assign software_clear = write_bus_event_status &
                              i_write_data[w1c_position(flag_index)];
      sticky_flag #(
        .RESET_VALUE(RESET_OTHER_STATUS)
      ) flag_cell (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_set(w1c_set[flag_index]),
        .i_clear(software_clear | w1c_extra_clear[flag_index]),
        .o_flag(w1c_flag[flag_index])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read-only status levels.

  logic bus_busy;
  logic receive_shift_full;
  logic transmitter_empty;
  logic addressed_as_slave;
  logic general_call_address;
  logic transmit_ready;

  // Levels are registered so a read sees a stable value; software cannot write them.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_busy <= RESET_OTHER_STATUS;
      receive_shift_full <= RESET_OTHER_STATUS;
      transmitter_empty <= RESET_TRANSMITTER_EMPTY;
      addressed_as_slave <= RESET_OTHER_STATUS;
      general_call_address <= RESET_OTHER_STATUS;
      transmit_ready <= RESET_TRANSMIT_READY;
    end else begin
      bus_busy <= i_bus_busy;
      receive_shift_full <= i_receive_shift_full;
      transmitter_empty <= i_transmitter_empty;
      addressed_as_slave <= i_addressed_as_slave;
      general_call_address <= i_general_call_address;
      transmit_ready <= i_transmit_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word assembly.

  logic [DATA_WIDTH-1:0] status_word;

  // Reserved positions fifteen, seven and six stay zero.
  always_comb begin
    status_word = '0;
    status_word[BIT_ARBITRATION_LOST] = w1c_flag[W1C_ARBITRATION_LOST];
    status_word[BIT_NO_ACK] = w1c_flag[W1C_NO_ACK];
    status_word[BIT_ACCESS_READY] = w1c_flag[W1C_ACCESS_READY];
    status_word[BIT_RECEIVE_READY] = w1c_flag[W1C_RECEIVE_READY];
    status_word[BIT_TRANSMIT_READY] = transmit_ready;
    status_word[BIT_STOP_DETECTED] = w1c_flag[W1C_STOP_DETECTED];
    status_word[BIT_GENERAL_CALL] = general_call_address;
    status_word[BIT_ADDRESSED_AS_SLAVE] = addressed_as_slave;
    status_word[BIT_TRANSMITTER_EMPTY] = transmitter_empty;
    status_word[BIT_RECEIVE_SHIFT_FULL] = receive_shift_full;
    status_word[BIT_BUS_BUSY] = bus_busy;
    status_word[BIT_ACK_WITHHELD_SENT] = w1c_flag[W1C_ACK_WITHHELD_SENT];
    status_word[BIT_SLAVE_DIRECTION] = w1c_flag[W1C_SLAVE_DIRECTION];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request.

  logic [ENABLE_WIDTH-1:0] pending_source;

  // Enable bit positions match the status low half; the addressed bit moves.
  always_comb begin
    pending_source = '0;
    pending_source[BIT_ARBITRATION_LOST] = status_word[BIT_ARBITRATION_LOST];
    pending_source[BIT_NO_ACK] = status_word[BIT_NO_ACK];
    pending_source[BIT_ACCESS_READY] = status_word[BIT_ACCESS_READY];
    pending_source[BIT_RECEIVE_READY] = status_word[BIT_RECEIVE_READY];
    pending_source[BIT_TRANSMIT_READY] = status_word[BIT_TRANSMIT_READY];
    pending_source[BIT_STOP_DETECTED] = status_word[BIT_STOP_DETECTED];
    pending_source[BIT_ENABLE_ADDRESSED] = status_word[BIT_ADDRESSED_AS_SLAVE];
  end

  // Level output, so it drops as soon as the flag clears or is disabled.
  // With FIFO mode the ready enables should stay off or this fires constantly.
  assign o_interrupt = |(pending_source & interrupt_enable_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  wire logic [DATA_WIDTH-1:0] next_read_data;
  logic [DATA_WIDTH-1:0] read_data;

  // Unmapped or idle reads return zero; reserved bits fill with zero too.
  assign next_read_data =
    read_extended_mode ? {{(DATA_WIDTH-1){1'h0}}, compat_timing_select} :
    read_interrupt_enable ? {{(DATA_WIDTH-ENABLE_WIDTH){1'h0}}, interrupt_enable_mask} :
    read_bus_event_status ? status_word :
    '0;

  // Data stand exactly one cycle after the read strobe.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      read_data <= '0;
    end else begin
      read_data <= next_read_data;
    end
  end

  assign o_read_data = read_data;

endmodule // i2c_irq_enable_status_regs

`default_nettype wire

// *** testbench/i2c_irq_enable_status_regs_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// Watches the register port and interrupt output of the register slice.
module i2c_irq_enable_status_regs_asserts
  import i2c_regs_pkg::*;
#(
  parameter int ADDRESS_WIDTH = ADDR_WIDTH
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rstn,
  // Register port.
  input wire logic [ADDRESS_WIDTH-1:0] i_address,
  input wire logic [DATA_WIDTH-1:0] i_write_data,
  input wire logic i_write_strobe,
  input wire logic i_read_strobe,
  input wire logic [DATA_WIDTH-1:0] o_read_data,
  // Engine inputs and block outputs.
  input wire logic i_stop_detected_event,
  input wire logic i_bus_busy,
  input wire logic o_compat_timing_select,
  input wire logic [ENABLE_WIDTH-1:0] o_interrupt_enable,
  input wire logic o_interrupt
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////
  // Decoded accesses, so each property reads as one relation.
  wire logic wr_mode = i_write_strobe && (i_address == OFFSET_EXTENDED_MODE);
  wire logic wr_en = i_write_strobe && (i_address == OFFSET_INTERRUPT_ENABLE);
  wire logic rd_mode = i_read_strobe && (i_address == OFFSET_EXTENDED_MODE);
  wire logic rd_en = i_read_strobe && (i_address == OFFSET_INTERRUPT_ENABLE);
  wire logic rd_stat = i_read_strobe && (i_address == OFFSET_BUS_EVENT_STATUS);
  ////////////////////////////////////////
  chk_idle_read_zero: assert property (!i_read_strobe |=> o_read_data == 16'h0000)
    else $error("read data not zero outside a read answer");
  chk_compat_write: assert property (wr_mode |=> o_compat_timing_select ==
    $past(i_write_data[BIT_COMPAT_TIMING])) else $error("compat bit not written");
  chk_enable_write: assert property (wr_en |=> o_interrupt_enable ==
    $past(i_write_data[ENABLE_WIDTH-1:0])) else $error("enable mask not written");
  chk_enable_hold: assert property (!wr_en |=> $stable(o_interrupt_enable))
    else $error("enable mask changed without a write");
  chk_mode_readback: assert property (rd_mode |=> o_read_data ==
    {15'h0000, $past(o_compat_timing_select)}) else $error("mode read wrong");
  chk_enable_readback: assert property (rd_en |=> o_read_data ==
    {9'h000, $past(o_interrupt_enable)}) else $error("enable read wrong");
  chk_stop_flag_seen: assert property (i_stop_detected_event ##1 !i_write_strobe ##1 rd_stat |=>
    o_read_data[BIT_STOP_DETECTED]) else $error("stop flag missing");
  chk_busy_level_seen: assert property (rd_stat |=> o_read_data[BIT_BUS_BUSY] ==
    $past(i_bus_busy, 2)) else $error("bus busy level wrong");
  chk_irq_follows_event: assert property (i_stop_detected_event && !wr_en &&
    o_interrupt_enable[BIT_STOP_DETECTED] |=> o_interrupt) else $error("no interrupt");
  // Main scenarios reached.
  cov_enable_write: cover property (wr_en);
  cov_status_read: cover property (rd_stat);
  cov_irq_raised: cover property ($rose(o_interrupt));
endmodule // i2c_irq_enable_status_regs_asserts
`default_nettype wire

// *** testbench/i2c_irq_enable_status_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_enable_status_regs_test;
  import i2c_regs_pkg::*;
  logic i_clock = 1'b0, i_rstn = 1'b0, i_write_strobe = 1'b0, i_read_strobe = 1'b0;
  logic [ADDR_WIDTH-1:0] i_address = 4'h0;
  logic [DATA_WIDTH-1:0] i_write_data = 16'h0000, o_read_data;
  logic [6:0] ev = 7'h00; // Events in flag index order.
  logic [5:0] lvl = 6'h09; // Busy, shift full, tx empty, addressed, general call, tx ready.
  logic start_stop = 1'b0, loopback = 1'b0, mod_en = 1'b1, o_compat_timing_select, o_interrupt;
  logic [ENABLE_WIDTH-1:0] o_interrupt_enable;
  int failures = 0, n_checks = 0;
  int pos [7] = '{0, 1, 2, 3, 5, 13, 14};
  logic [15:0] base, bit_p;
  always #25 i_clock = ~i_clock;
  i2c_irq_enable_status_regs u_i2c_irq_enable_status_regs (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_address(i_address), .i_write_data(i_write_data),
    .i_write_strobe(i_write_strobe), .i_read_strobe(i_read_strobe), .o_read_data(o_read_data),
    .i_arbitration_lost_event(ev[0]), .i_no_ack_event(ev[1]), .i_access_ready_event(ev[2]),
    .i_receive_ready_event(ev[3]), .i_stop_detected_event(ev[4]),
    .i_ack_withheld_sent_event(ev[5]), .i_slave_transmit_addressed_event(ev[6]),
    .i_start_or_stop_seen(start_stop), .i_digital_loopback(loopback), .i_module_enable(mod_en),
    .i_bus_busy(lvl[5]), .i_receive_shift_full(lvl[4]), .i_transmitter_empty(lvl[3]),
    .i_addressed_as_slave(lvl[2]), .i_general_call_address(lvl[1]), .i_transmit_ready(lvl[0]),
    .o_compat_timing_select(o_compat_timing_select), .o_interrupt_enable(o_interrupt_enable),
    .o_interrupt(o_interrupt));
  ////////////////////////////////////////
  // Comparison and bus tasks; each access ends half a cycle after its strobe is taken.
  task automatic check16(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check1(input string name, input logic exp, input logic got);
    check16(name, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_address <= a;
    i_write_data <= d;
    i_write_strobe <= 1'b1;
    @(posedge i_clock);
    i_write_strobe <= 1'b0;
    @(negedge i_clock);
  endtask
  // Read data stands only in the cycle after the strobe, so it is sampled there.
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clock);
    i_address <= a;
    i_read_strobe <= 1'b1;
    @(posedge i_clock);
    i_read_strobe <= 1'b0;
    @(negedge i_clock);
    check16("read_data", exp, o_read_data);
  endtask
  task automatic pulse(input int i);
    @(posedge i_clock);
    ev[i] <= 1'b1;
    @(posedge i_clock);
    ev[i] <= 1'b0;
    @(negedge i_clock);
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // A hang counts as a failure.
  initial begin
    repeat (3000) @(posedge i_clock);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge i_clock);
    i_rstn <= 1'b1;
    check1("compat", 1'b1, o_compat_timing_select);
    rd(4'h0, 16'h0001);
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0410);
    rd(4'hF, 16'h0000);
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h0000);
    check1("compat", 1'b0, o_compat_timing_select);
    wr(4'h0, 16'h0001);
    rd(4'h0, 16'h0001);
    // No FIFO mode in this bench, so the ready enables may be set.
    wr(4'h1, 16'hFFFF);
    rd(4'h1, 16'h007F);
    check1("irq", 1'b1, o_interrupt);
    // Each flag: set, survive a write of zero, clear on one, gate the interrupt.
    base = 16'h0410;
    for (int i = 0; i < 7; i++) begin
      bit_p = 16'h0001 << pos[i];
      wr(4'h1, (pos[i] < 6) ? bit_p : 16'h0000);
      pulse(i);
      check1("irq", pos[i] < 6, o_interrupt);
      rd(4'h2, base | bit_p);
      wr(4'h2, ~bit_p);
      rd(4'h2, base | bit_p);
      wr(4'h2, bit_p);
      rd(4'h2, base);
      check1("irq", 1'b0, o_interrupt);
    end
    wr(4'h1, 16'h0020);
    pulse(4);
    wr(4'h1, 16'h0000);
    check1("irq", 1'b0, o_interrupt);
    wr(4'h1, 16'h0020);
    check1("irq", 1'b1, o_interrupt);
    // A set in the clearing cycle must win.
    @(posedge i_clock);
    ev[4] <= 1'b1;
    i_address <= OFFSET_BUS_EVENT_STATUS;
    i_write_data <= 16'h0020;
    i_write_strobe <= 1'b1;
    @(posedge i_clock);
    ev[4] <= 1'b0;
    i_write_strobe <= 1'b0;
    rd(4'h2, 16'h0430);
    wr(4'h2, 16'h0020);
    @(posedge i_clock);
    lvl <= 6'h36;
    wr(4'h2, 16'hFFFF);
    rd(4'h2, 16'h1B00);
    wr(4'h1, 16'h0040);
    check1("irq", 1'b1, o_interrupt);
    wr(4'h1, 16'h0000);
    @(posedge i_clock);
    lvl <= 6'h09;
    // Slave direction and withheld acknowledge have hardware clears too.
    pulse(6);
    @(posedge i_clock);
    start_stop <= 1'b1;
    @(posedge i_clock);
    start_stop <= 1'b0;
    rd(4'h2, 16'h0410);
    pulse(6);
    @(posedge i_clock);
    loopback <= 1'b1;
    rd(4'h2, 16'h0410);
    @(posedge i_clock);
    loopback <= 1'b0;
    pulse(5);
    @(posedge i_clock);
    mod_en <= 1'b0;
    rd(4'h2, 16'h0410);
    @(posedge i_clock);
    mod_en <= 1'b1;
    // Reset in mid-run restores the defaults.
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h007F);
    @(posedge i_clock);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clock);
    check1("compat", 1'b1, o_compat_timing_select);
    check16("enable", 16'h0000, {9'h000, o_interrupt_enable});
    check1("irq", 1'b0, o_interrupt);
    i_rstn <= 1'b1;
    rd(4'h1, 16'h0000);
    tally_and_finish();
  end
endmodule // i2c_irq_enable_status_regs_test
bind i2c_irq_enable_status_regs i2c_irq_enable_status_regs_asserts #(
  .ADDRESS_WIDTH(ADDRESS_WIDTH)
) u_i2c_irq_enable_status_regs_asserts (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_address(i_address), .i_write_data(i_write_data),
  .i_write_strobe(i_write_strobe), .i_read_strobe(i_read_strobe), .o_read_data(o_read_data),
  .i_stop_detected_event(i_stop_detected_event), .i_bus_busy(i_bus_busy),
  .o_compat_timing_select(o_compat_timing_select), .o_interrupt_enable(o_interrupt_enable),
  .o_interrupt(o_interrupt));
`default_nettype wire
